// [hdl/ddc_chan_if.sv]
// Interface joining the top to one down-converter channel
`timescale 1ns/1ps
interface ddc_chan_if;
  import ddc_pkg::*;
  logic                     en;
  logic                     real_mode;
  logic                     gain6;
  logic                     gain3;
  logic                     invert;
  logic                     restart;
  logic [2:0]               dec_log;
  logic [2:0]               res_code;
  logic [FREQ_W-1:0]        freq;
  logic signed [SMP_W-1:0]  smp;
  logic                     smp_vld;
  calc_t                    out_i;
  calc_t                    out_q;
  logic                     out_vld;

  modport ctrl (output en, real_mode, gain6, gain3, invert, restart, dec_log, res_code, freq,
                output smp, smp_vld, input out_i, out_q, out_vld);
  modport chan (input en, real_mode, gain6, gain3, invert, restart, dec_log, res_code, freq,
                input smp, smp_vld, output out_i, out_q, out_vld);
endinterface

// [hdl/ddc_channel.sv]
// One down-converter channel: oscillator, mixer, integrate-and-dump decimator, gain, truncation
`timescale 1ns/1ps
module ddc_channel (
  input  wire logic clk_i,
  input  wire logic rst_i,
  ddc_chan_if.chan  cfg
);
  import ddc_pkg::*;

  // Quarter sine, 9 points, amplitude 2047
  function automatic logic [11:0] qsin(input logic [3:0] k);
    case (k)
      4'h0:    return 12'h000;
      4'h1:    return 12'h18f;
      4'h2:    return 12'h30f;
      4'h3:    return 12'h471;
      4'h4:    return 12'h5a7;
      4'h5:    return 12'h6a6;
      4'h6:    return 12'h763;
      4'h7:    return 12'h7d8;
      default: return 12'h7ff;
    endcase
  endfunction

  function automatic logic signed [11:0] sine(input logic [4:0] p);
    logic [3:0] k;
    k = p[3] ? (4'h8 - {1'b0, p[2:0]}) : {1'b0, p[2:0]};
    return p[4] ? -$signed(qsin(k)) : $signed(qsin(k));
  endfunction

  function automatic calc_t sat(input logic signed [CALC_W+1:0] v);
    if (v > 22'sh07ffff) return calc_t'(20'h7ffff);
    if (v < -22'sh080000) return calc_t'(20'h80000);
    return calc_t'(v);
  endfunction

  // 6 dB doubles; 3 dB approximates 1.406
  function automatic calc_t gain(input calc_t v, input logic g6, input logic g3);
    logic signed [CALC_W+1:0] w;
    w = {{2{v[CALC_W-1]}}, v};
    if (g6) return sat(w <<< 1);
    if (g3) return sat(w + (w >>> 2) + (w >>> 3) + (w >>> 5));
    return v;
  endfunction

  logic [FREQ_W-1:0]       phase;
  logic [FREQ_W-1:0]       act_freq;
  logic [4:0]              cnt;
  calc_t                   mi;
  calc_t                   mq;
  logic                    mvld;
  calc_t                   acc_i;
  calc_t                   acc_q;
  calc_t                   out_i;
  calc_t                   out_q;
  logic                    out_vld;

  wire logic signed [11:0] cos_w   = sine(phase[31:27] + 5'h08);
  wire logic signed [11:0] sin_w   = sine(phase[31:27]);
  wire logic signed [29:0] prod_i  = cfg.smp * cos_w;
  wire logic signed [29:0] prod_q  = cfg.smp * sin_w;
  wire calc_t              sq      = calc_t'(prod_q[28:9]);
  wire calc_t              next_mi = cfg.real_mode ? calc_t'({cfg.smp, 2'b00})
                                                   : calc_t'(prod_i[28:9]);
  wire calc_t              next_mq = cfg.real_mode ? '0 : (cfg.invert ? sq : -sq);
  wire logic               last    = (cnt == 5'((6'h01 << cfg.dec_log) - 6'h01));
  wire calc_t              sum_i   = acc_i + (mi >>> cfg.dec_log);
  wire calc_t              sum_q   = acc_q + (mq >>> cfg.dec_log);
  wire calc_t              mask    = res_mask(cfg.res_code);
  wire logic               g6      = cfg.gain6 && !cfg.real_mode;
  wire logic               g3      = cfg.gain3 && cfg.real_mode;

  assign cfg.out_i   = out_i;
  assign cfg.out_q   = out_q;
  assign cfg.out_vld = out_vld;

  // Oscillator: new word only on restart, phase advances per input sample in complex mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase    <= '0;
      act_freq <= FREQ_RESET;
    end else if (cfg.restart) begin
      act_freq <= cfg.freq;
      phase    <= '0;
    end else if (cfg.en && cfg.smp_vld && !cfg.real_mode) begin
      phase <= phase + act_freq;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mi   <= '0;
      mq   <= '0;
      mvld <= 1'b0;
    end else begin
      mi   <= next_mi;
      mq   <= next_mq;
      mvld <= cfg.en && cfg.smp_vld;
    end
  end

  // Integrate and dump over N mixed samples
  always_ff @(posedge clk_i) begin
    if (rst_i || !cfg.en || cfg.restart) begin
      cnt     <= '0;
      acc_i   <= '0;
      acc_q   <= '0;
      out_vld <= 1'b0;
      if (rst_i) begin
        out_i <= '0;
        out_q <= '0;
      end
    end else begin
      out_vld <= mvld && last;
      if (mvld) begin
        cnt   <= last ? 5'h00 : cnt + 5'h01;
        acc_i <= last ? '0 : sum_i;
        acc_q <= last ? '0 : sum_q;
        if (last) begin
          out_i <= gain(sum_i, g6, g3) & mask;
          out_q <= gain(sum_q, g6, g3) & mask;
        end
      end
    end
  end

  logic [5:0] gap;
  always_ff @(posedge clk_i) begin
    if (rst_i || !cfg.en || cfg.restart) gap <= '0;
    else if (mvld) gap <= (mvld && last) ? 6'h00 : gap + 6'h01;
  end

  property p_restart_load;
    @(posedge clk_i) disable iff (rst_i)
    cfg.restart |=> (act_freq == $past(cfg.freq)) && (phase == '0);
  endproperty
  a_restart_load: assert property (p_restart_load) else $error("freq not loaded");

  property p_freq_hold;
    @(posedge clk_i) disable iff (rst_i)
    !cfg.restart |=> $stable(act_freq);
  endproperty
  a_freq_hold: assert property (p_freq_hold) else $error("freq changed early");

  property p_phase_step;
    @(posedge clk_i) disable iff (rst_i)
    (cfg.en && cfg.smp_vld && !cfg.real_mode && !cfg.restart)
      |=> phase == $past(phase) + $past(act_freq);
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase step wrong");

  property p_dec_count;
    @(posedge clk_i) disable iff (rst_i)
    (mvld && last && cfg.en && !cfg.restart)
      |-> (6'(gap + 6'h01) == (6'h01 << cfg.dec_log)) ##1 out_vld;
  endproperty
  a_dec_count: assert property (p_dec_count) else $error("decimation count");

  property p_real_q;
    @(posedge clk_i) disable iff (rst_i)
    (out_vld && cfg.real_mode && $stable(cfg.real_mode)) |-> out_q == '0;
  endproperty
  a_real_q: assert property (p_real_q) else $error("real mode q nonzero");

  property p_trunc;
    @(posedge clk_i) disable iff (rst_i)
    (out_vld && $stable(cfg.res_code)) |-> ((out_i | out_q) & ~mask) == '0;
  endproperty
  a_trunc: assert property (p_trunc) else $error("low bits not cleared");
endmodule

// [hdl/ddc_pkg.sv]
// Package with register map, field positions, widths and tables for the down converter
package ddc_pkg;
  localparam int          WB_AW        = 4;
  localparam int          SMP_W        = 18;
  localparam int          CALC_W       = 20;
  localparam int          FREQ_W       = 32;
  localparam int          CNT_W        = 16;
  localparam logic [3:0]  ADR_CTRL     = 4'h0;
  localparam logic [3:0]  ADR_FREQ0    = 4'h4;
  localparam logic [3:0]  ADR_FREQ1    = 4'h8;
  localparam logic [3:0]  ADR_STATUS   = 4'hc;
  localparam int          B_ENABLE     = 0;
  localparam int          B_REAL       = 1;
  localparam int          B_DUAL       = 2;
  localparam int          B_GAIN6      = 3;
  localparam int          B_GAIN3      = 4;
  localparam int          B_INVERT     = 5;
  localparam int          B_RESTART    = 6;
  localparam int          F_DEC_LO     = 8;
  localparam int          F_RES_LO     = 12;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001 << F_DEC_LO;
  localparam logic [31:0] CTRL_MASK    = 32'h0000_777f;
  localparam logic [31:0] FREQ_RESET   = 32'h0000_0000;
  localparam logic [2:0]  DEC_LOG_MIN  = 3'h1;
  localparam logic [2:0]  DEC_LOG_MAX  = 3'h5;
  localparam logic [2:0]  RES_CODE_MAX = 3'h6;

  typedef logic signed [CALC_W-1:0] calc_t;

  // Decimation code kept within 1..5, a ratio of 2..32
  function automatic logic [2:0] dec_clamp(input logic [2:0] c);
    if (c < DEC_LOG_MIN) return DEC_LOG_MIN;
    if (c > DEC_LOG_MAX) return DEC_LOG_MAX;
    return c;
  endfunction

  // Output width code 0..6 means 14..20 bits
  function automatic logic [2:0] res_clamp(input logic [2:0] c);
    return (c > RES_CODE_MAX) ? RES_CODE_MAX : c;
  endfunction

  // Mask keeping the top 14+code bits of a 20-bit word
  function automatic calc_t res_mask(input logic [2:0] c);
    logic [CALC_W-1:0] ones;
    ones = (20'h00001 << (3'h6 - c)) - 20'h00001;
    return calc_t'(~ones);
  endfunction
endpackage

// [hdl/ddc_top.sv]
// Dual-band down converter with Wishbone registers, bypass path and two output lane groups
// Function
// - Path is off unless enabled in a register; otherwise samples pass straight through.
// - Decimation by 2, 4, 8, 16 or 32 is selectable.
// - Complex mode mixes samples with a 32-bit oscillator before decimation.
// - Real mode bypasses the mixer; the filter is a plain low-pass decimator.
// - Filter arithmetic is 20 bits wide.
// - Results are truncated to the selected output width before output.
// - A selector lets one sample stream feed both channels at once.
// - Each channel has its own independently tuned frequency word.
// - Second channel results leave on the second-band lanes.
// - Frequency word is signed two's complement over minus to plus half rate.
// - New frequency acts only after restart bit toggle or sync pin toggle.
// - Optional 6 dB gain in complex mode.
// - Optional 3 dB gain in real mode.
`timescale 1ns/1ps
module ddc_top (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [ddc_pkg::WB_AW-1:0]    wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic signed [ddc_pkg::SMP_W-1:0] smp_i,
  input  wire logic                         smp_vld_i,
  input  wire logic                         sync_i,
  output ddc_pkg::calc_t                    lane_i_o,
  output ddc_pkg::calc_t                    lane_q_o,
  output logic                              lane_vld_o,
  output ddc_pkg::calc_t                    second_band_lanes_i_o,
  output ddc_pkg::calc_t                    second_band_lanes_q_o,
  output logic                              second_band_lanes_vld_o
);
  import ddc_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  logic [31:0]      ctrl;
  logic [FREQ_W-1:0] freq0;
  logic [FREQ_W-1:0] freq1;
  logic [CNT_W-1:0] out_cnt;
  logic             restart_seen;
  logic             sync_m;
  logic             sync_s;
  logic             sync_d;
  logic             restart;

  ddc_chan_if ch0 ();
  ddc_chan_if ch1 ();

  wire logic       wr        = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  wire logic       rd        = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  wire logic       en        = ctrl[B_ENABLE];
  wire logic       dual      = en && ctrl[B_DUAL];
  wire logic [2:0] dec_log   = dec_clamp(ctrl[F_DEC_LO +: 3]);
  wire logic [2:0] res_code  = res_clamp(ctrl[F_RES_LO +: 3]);
  wire logic       next_rst  = (ctrl[B_RESTART] != restart_seen) || (sync_s != sync_d);
  wire logic [31:0] status   = {out_cnt, 14'h0000, dual, en};
  wire logic [31:0] rd_data  = (wb_adr_i == ADR_CTRL)   ? ctrl :
                               (wb_adr_i == ADR_FREQ0)  ? freq0 :
                               (wb_adr_i == ADR_FREQ1)  ? freq1 :
                               (wb_adr_i == ADR_STATUS) ? status : 32'h0000_0000;

  // Both channels see the same stream; the second only in dual mode
  assign ch0.en        = en;
  assign ch1.en        = dual;
  assign ch0.smp       = smp_i;
  assign ch1.smp       = smp_i;
  assign ch0.smp_vld   = smp_vld_i;
  assign ch1.smp_vld   = smp_vld_i;
  assign ch0.freq      = freq0;
  assign ch1.freq      = freq1;
  assign ch0.real_mode = ctrl[B_REAL];
  assign ch1.real_mode = ctrl[B_REAL];
  assign ch0.gain6     = ctrl[B_GAIN6];
  assign ch1.gain6     = ctrl[B_GAIN6];
  assign ch0.gain3     = ctrl[B_GAIN3];
  assign ch1.gain3     = ctrl[B_GAIN3];
  assign ch0.invert    = ctrl[B_INVERT];
  assign ch1.invert    = ctrl[B_INVERT];
  assign ch0.restart   = restart;
  assign ch1.restart   = restart;
  assign ch0.dec_log   = dec_log;
  assign ch1.dec_log   = dec_log;
  assign ch0.res_code  = res_code;
  assign ch1.res_code  = res_code;

  ddc_channel u_ch0 (.clk_i(clk_i), .rst_i(rst_i), .cfg(ch0));
  ddc_channel u_ch1 (.clk_i(clk_i), .rst_i(rst_i), .cfg(ch1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl  <= CTRL_RESET;
      freq0 <= FREQ_RESET;
      freq1 <= FREQ_RESET;
    end else if (wr) begin
      if (wb_adr_i == ADR_CTRL) ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & CTRL_MASK;
      if (wb_adr_i == ADR_FREQ0) freq0 <= merge(freq0, wb_dat_i, wb_sel_i);
      if (wb_adr_i == ADR_FREQ1) freq1 <= merge(freq1, wb_dat_i, wb_sel_i);
    end
  end

  // Sync pin: two-flop synchroniser, then a toggle detector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_m       <= 1'b0;
      sync_s       <= 1'b0;
      sync_d       <= 1'b0;
      restart_seen <= 1'b0;
      restart      <= 1'b0;
    end else begin
      sync_m       <= sync_i;
      sync_s       <= sync_m;
      sync_d       <= sync_s;
      restart_seen <= ctrl[B_RESTART];
      restart      <= next_rst;
    end
  end

  // Primary lanes carry channel 0 or the raw stream; second-band lanes carry channel 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane_i_o                <= '0;
      lane_q_o                <= '0;
      lane_vld_o              <= 1'b0;
      second_band_lanes_i_o   <= '0;
      second_band_lanes_q_o   <= '0;
      second_band_lanes_vld_o <= 1'b0;
      out_cnt                 <= '0;
    end else begin
      lane_i_o                <= en ? ch0.out_i : calc_t'({smp_i, 2'b00});
      lane_q_o                <= en ? ch0.out_q : '0;
      lane_vld_o              <= en ? ch0.out_vld : smp_vld_i;
      second_band_lanes_i_o   <= ch1.out_i;
      second_band_lanes_q_o   <= ch1.out_q;
      second_band_lanes_vld_o <= dual && ch1.out_vld;
      if (lane_vld_o) out_cnt <= out_cnt + 16'h0001;
    end
  end

  property p_bypass;
    @(posedge clk_i) disable iff (rst_i)
    (!en && smp_vld_i) |=> lane_vld_o && (lane_i_o == calc_t'({$past(smp_i), 2'b00}));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass sample wrong");

  property p_second_band;
    @(posedge clk_i) disable iff (rst_i)
    second_band_lanes_vld_o |-> $past(dual) && $past(ch1.out_vld);
  endproperty
  a_second_band: assert property (p_second_band) else $error("second band strobe");

  property p_restart_sync;
    @(posedge clk_i) disable iff (rst_i)
    (sync_s != sync_d) |=> restart;
  endproperty
  a_restart_sync: assert property (p_restart_sync) else $error("sync toggle lost");

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack timing");

  property p_bypass_q;
    @(posedge clk_i) disable iff (rst_i)
    !en |=> lane_q_o == '0;
  endproperty
  a_bypass_q: assert property (p_bypass_q) else $error("bypass q nonzero");

  property p_primary_lane;
    @(posedge clk_i) disable iff (rst_i)
    (en && ch0.out_vld) |=> lane_vld_o && (lane_i_o == $past(ch0.out_i));
  endproperty
  a_primary_lane: assert property (p_primary_lane) else $error("primary lane data");

  property p_second_data;
    @(posedge clk_i) disable iff (rst_i)
    (dual && ch1.out_vld)
      |=> second_band_lanes_vld_o && (second_band_lanes_i_o == $past(ch1.out_i))
          && (second_band_lanes_q_o == $past(ch1.out_q));
  endproperty
  a_second_data: assert property (p_second_data) else $error("second band data");

  property p_restart_ctrl;
    @(posedge clk_i) disable iff (rst_i)
    (ctrl[B_RESTART] != restart_seen) |=> restart;
  endproperty
  a_restart_ctrl: assert property (p_restart_ctrl) else $error("restart bit toggle lost");

  property p_restart_only;
    @(posedge clk_i) disable iff (rst_i)
    !next_rst |=> !restart;
  endproperty
  a_restart_only: assert property (p_restart_only) else $error("spurious restart");

  property p_ctrl_write;
    @(posedge clk_i) disable iff (rst_i)
    (wr && (wb_adr_i == ADR_CTRL) && (wb_sel_i == 4'hf))
      |=> ctrl == ($past(wb_dat_i) & CTRL_MASK);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write lost");
endmodule

// [test/ddc_stream_src.sv]
// Converter sample source feeding the down converter
`timescale 1ns/1ps
module ddc_stream_src (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          run_i,
  input  wire logic                          slow_i,
  input  wire logic                          dc_i,
  output logic signed [ddc_pkg::SMP_W-1:0]   smp_o = '0,
  output logic                               vld_o = 1'b0
);
  import ddc_pkg::*;
  logic [31:0] rng;
  logic        ph;
  logic        go;
  assign go = run_i && !(slow_i && ph);
  // Idle cycles show the inverse of the previous cycle's output, never a held value
  always @(posedge clk_i) begin
    rng = rst_i ? 32'h0000_0061 : rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    ph <= rst_i ? 1'b0 : ~ph;
    vld_o <= !rst_i && go;
    smp_o <= rst_i ? '0 : go ? (dc_i ? 18'sh0_4000 : rng[SMP_W-1:0]) : ~smp_o;
  end
endmodule

// [test/ddc_top_tb_top.sv]
// Self-checking bench for the dual-band down converter
`timescale 1ns/1ps
module ddc_top_tb_top;
  import ddc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic run = 1'b0, slow = 1'b0, dc = 1'b0, sync = 1'b0;
  logic [3:0] adr = '0, sel = '0;
  logic [31:0] wdat = '0, rdat, ctrl_sh = CTRL_RESET, seed = 32'h0000_0061;
  logic ack, vld, lv, sv, q0nz = 1'b0, q1nz = 1'b0;
  logic signed [SMP_W-1:0] smp;
  calc_t li, lq, si, sq, last_i, racc;
  calc_t ev[$];
  int eq0[$], eq1[$];
  int err_count = 0, n_checks = 0, cyc_n = 0, cnt = 0, nd = 2, lv_total = 0, dl = 1;

  always #10 clk_i = ~clk_i;

  ddc_stream_src u_src (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .slow_i(slow),
    .dc_i(dc), .smp_o(smp), .vld_o(vld));

  ddc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .smp_i(smp), .smp_vld_i(vld), .sync_i(sync), .lane_i_o(li),
    .lane_q_o(lq), .lane_vld_o(lv), .second_band_lanes_i_o(si),
    .second_band_lanes_q_o(sq), .second_band_lanes_vld_o(sv));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Low bits dropped for an output resolution code
  function automatic calc_t lowm(input logic [2:0] r);
    return calc_t'((20'h00001 << (3'h6 - r)) - 20'h00001);
  endfunction

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (exp !== got) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
          output logic [31:0] q);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (k == 20) begin
      err_count++;
      summarize();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Every control write toggles the restart bit so the model starts from a clean frame
  task cfg(input logic [31:0] v);
    logic [31:0] r;
    v[B_RESTART] = ~ctrl_sh[B_RESTART];
    wb(1'b1, ADR_CTRL, 4'hf, v, r);
    ctrl_sh = v;
    repeat (8) @(posedge clk_i);
    cnt = 0;
    nd = 1 << v[10:8];
    dl = v[10:8];
  endtask

  task play(input int n, input logic s);
    slow <= s;
    run <= 1'b1;
    repeat (n) @(posedge clk_i);
    run <= 1'b0;
    repeat (12) @(posedge clk_i);
    check("pending outputs", 0, eq0.size() + eq1.size());
  endtask

  task automatic lane(ref int q[$], input calc_t i, input calc_t qv);
    int k;
    k = (q.size() > 0) ? cyc_n - q.pop_front() : 0;
    check("output delay", 1, k >= 1 && k <= 5);
    if (ctrl_sh[0]) check("truncated bits", 0, i & ((20'h1 << (6 - ctrl_sh[14:12])) - 1));
    if (ctrl_sh[1] || !ctrl_sh[0]) check("real q", 0, qv);
  endtask

  // Reference model: bypass values, one result per N samples, lane pairing
  always @(posedge clk_i) begin
    cyc_n++;
    if (!rst_i && vld === 1'b1) begin
      if (!ctrl_sh[0]) begin
        eq0.push_back(cyc_n);
        ev.push_back(calc_t'({smp, 2'b00}));
      end else begin
        cnt++;
        racc = (cnt == 1 ? calc_t'(0) : racc) + (calc_t'({smp, 2'b00}) >>> dl);
        if (cnt == nd) begin
          cnt = 0;
          eq0.push_back(cyc_n);
          if (ctrl_sh[2]) eq1.push_back(cyc_n);
          if (ctrl_sh[1] && !ctrl_sh[4]) ev.push_back(racc & ~lowm(ctrl_sh[14:12]));
        end
      end
    end
    if (lv === 1'b1) begin
      lv_total++;
      lane(eq0, li, lq);
      if (!ctrl_sh[0]) check("bypass i", ev.pop_front(), li);
      if (ctrl_sh[0] && ctrl_sh[1] && !ctrl_sh[4]) check("real i", ev.pop_front(), li);
      if (lq !== '0) q0nz = 1'b1;
      last_i = li;
    end
    if (sv === 1'b1) begin
      check("second band in dual", 1, ctrl_sh[2] & ctrl_sh[0]);
      lane(eq1, si, sq);
      if (sq !== '0) q1nz = 1'b1;
    end
  end

  initial begin
    logic [31:0] r;
    calc_t a;
    int m, d;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADR_CTRL, 4'hf, 0, r);
    check("ctrl reset", CTRL_RESET, r);
    wb(1'b0, ADR_FREQ1, 4'hf, 0, r);
    check("freq1 reset", FREQ_RESET, r);
    seed = xs(seed);
    wb(1'b1, ADR_FREQ0, 4'hf, seed, r);
    wb(1'b0, ADR_FREQ0, 4'hf, 0, r);
    check("freq0", seed, r);
    wb(1'b1, ADR_FREQ1, 4'h5, ~seed, r);
    wb(1'b0, ADR_FREQ1, 4'hf, 0, r);
    check("freq1 bytes", ~seed & 32'h00ff_00ff, r);
    wb(1'b1, 4'h2, 4'hf, seed, r);
    wb(1'b0, 4'h2, 4'hf, 0, r);
    check("unmapped", 0, r);
    cfg(32'hffff_d2bc);
    wb(1'b0, ADR_CTRL, 4'hf, 0, r);
    check("ctrl fields", ctrl_sh & CTRL_MASK, r);
    play(40, 1'b0);
    play(40, 1'b1);
    for (m = 0; m < 2; m++) begin
      for (d = 1; d <= 5; d++) begin
        seed = xs(seed);
        wb(1'b1, ADR_FREQ0, 4'hf, m ? seed : 32'h0, r);
        wb(1'b1, ADR_FREQ1, 4'hf, ~seed, r);
        cfg(32'h1 | (!m) << 1 | d[0] << 2 | d << 8 | ((d + 2 * m) % 7) << 12);
        play(8 << d, d[1]);
      end
    end
    wb(1'b0, ADR_STATUS, 4'hf, 0, r);
    check("status count", lv_total[15:0], r[31:16]);
    check("status enable", ctrl_sh[0], r[0]);
    dc <= 1'b1;
    wb(1'b1, ADR_FREQ0, 4'hf, 0, r);
    wb(1'b1, ADR_FREQ1, 4'hf, 32'h0800_0000, r);
    cfg(32'h0000_6105);
    q0nz = 1'b0;
    q1nz = 1'b0;
    play(40, 1'b0);
    check("primary q at zero freq", 0, q0nz);
    check("second band q", 1, q1nz);
    wb(1'b1, ADR_FREQ0, 4'hf, 32'h0800_0000, r);
    play(40, 1'b0);
    check("freq held until restart", 0, q0nz);
    sync <= ~sync;
    repeat (10) @(posedge clk_i);
    cnt = 0;
    play(40, 1'b0);
    check("freq after sync", 1, q0nz);
    wb(1'b1, ADR_FREQ0, 4'hf, 0, r);
    cfg(32'h0000_6103);
    play(20, 1'b0);
    a = last_i;
    cfg(32'h0000_6113);
    play(20, 1'b0);
    check("3 dB gain", 1, last_i > a);
    cfg(32'h0000_6101);
    play(20, 1'b0);
    a = last_i;
    cfg(32'h0000_6109);
    play(20, 1'b0);
    check("6 dB gain", 1, last_i > a);
    summarize();
  end
endmodule
